// file: sfrpg_regs.vh
/*
 * Constants for the SFR paging and stack pointer block: SFR addresses,
 * pages, reset values and field positions.
 * Assumes one 8-bit direct-address SFR port from the core.
 */
// Functional notes
// - Stack pointer marks last used byte; push writes at pointer plus one, then increments.
// - Reset loads stack pointer with 0x07 so first push lands at 0x08.
// - Stack may sit anywhere in 256-byte data memory, full 256-byte depth.
// - 32-bit record shifts in one bit per push/increment, two per call.
// - Record shifts out one bit per pop/decrement, two per return.
// - Record flags overflow and underflow of its 32 bits to debug logic.
// - Direct accesses at 0x80 to 0xFF go to SFR space, not data memory.
// - SFRs at addresses ending 0x0 or 0x8 allow bit access; others byte only.
// - Page select picks one of 256 pages; only 0, 1, 2, 3 and F exist.
// - All-page registers answer at their address whatever page is selected.
// - Interrupt entry: middle to bottom, page to middle, load interrupt flag page.
// - Interrupt return: middle to page register, bottom to middle.
// - Empty bottom entry reads 0x00 and that value moves to middle on pop.
// - Software writes to stack entries only store; only entry/return move stack.
// - Nested interrupt push overwrites bottom entry, even a software-written one.
// - Software may rewrite page and stack entries inside a routine to redirect return.
// - All three page-stack entries readable and writable as separate SFRs.
// - Auto paging enable resets set; clearing it stops switching, pushes and pops.
`ifndef SFRPG_REGS_VH
`define SFRPG_REGS_VH

`define SFRPG_SFR_BASE       8'h80
`define SFRPG_ADDR_SP        8'h81
`define SFRPG_ADDR_PAGE      8'h84
`define SFRPG_ADDR_NEXT      8'h85
`define SFRPG_ADDR_LAST      8'h86
`define SFRPG_ADDR_PGCN      8'h96
`define SFRPG_PAGE_F         8'h0f
`define SFRPG_PAGE_3         8'h03
`define SFRPG_SP_RST         8'h07
`define SFRPG_PAGE_RST       8'h00
`define SFRPG_EMPTY          8'h00
`define SFRPG_PGCN_RST       8'h01
`define SFRPG_PGEN_BIT       0
`define SFRPG_BITADR_MASK    8'h07
`define SFRPG_ONE            8'h01
`define SFRPG_REC_DEPTH      6'd32
`define SFRPG_REC_EMPTY      6'd0
`define SFRPG_REC_ZERO       32'h0000_0000

`endif

// file: sfrpg_record.v
/*
 * Stack record: 32-bit shift register that mirrors stack activity for
 * the debug logic, with overflow and underflow pulses.
 * Assumes at most one of the four shift requests per cycle.
 */
`timescale 1ns/1ps
`include "sfrpg_regs.vh"

module sfrpg_record (
   // Clock and reset
   input  wire        clk_in,
   input  wire        rst_n_in,
   // Shift requests
   input  wire        in1_in,
   input  wire        in2_in,
   input  wire        out1_in,
   input  wire        out2_in,
   // Debug view
   output reg  [31:0] record_out,
   output reg  [5:0]  depth_out,
   output reg         ovf_out,
   output reg         unf_out
);

   ////////////////////////////////////////////////////////////////////////
   reg [31:0] rec_nxt;
   reg [5:0]  dep_nxt;
   reg        ovf_nxt;
   reg        unf_nxt;

   // Depth saturates; lost bits cannot be rebuilt, hence the pulse
   always @* begin
      rec_nxt = record_out;
      dep_nxt = depth_out;
      ovf_nxt = 1'b0;
      unf_nxt = 1'b0;
      if (in1_in) begin
         rec_nxt = {record_out[30:0], 1'b0};
         if (depth_out == `SFRPG_REC_DEPTH)
            ovf_nxt = 1'b1;
         else
            dep_nxt = depth_out + 6'd1;
      end else if (in2_in) begin
         rec_nxt = {record_out[29:0], 2'b11};
         if (depth_out > (`SFRPG_REC_DEPTH - 6'd2)) begin
            ovf_nxt = 1'b1;
            dep_nxt = `SFRPG_REC_DEPTH;
         end else
            dep_nxt = depth_out + 6'd2;
      end else if (out1_in) begin
         rec_nxt = {1'b0, record_out[31:1]};
         if (depth_out == `SFRPG_REC_EMPTY)
            unf_nxt = 1'b1;
         else
            dep_nxt = depth_out - 6'd1;
      end else if (out2_in) begin
         rec_nxt = {2'b00, record_out[31:2]};
         if (depth_out < 6'd2) begin
            unf_nxt = 1'b1;
            dep_nxt = `SFRPG_REC_EMPTY;
         end else
            dep_nxt = depth_out - 6'd2;
      end
   end

   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         record_out <= `SFRPG_REC_ZERO;
         depth_out  <= `SFRPG_REC_EMPTY;
         ovf_out    <= 1'b0;
         unf_out    <= 1'b0;
      end else begin
         record_out <= rec_nxt;
         depth_out  <= dep_nxt;
         ovf_out    <= ovf_nxt;
         unf_out    <= unf_nxt;
      end
   end

endmodule

// file: sfrpg_core.v
/*
 * SFR paging unit: stack pointer, page select, three-entry page stack,
 * page control, direct-address SFR port and the stack record.
 * Assumes the sequencer and interrupt controller raise one-cycle event
 * strobes on this clock, one stack event per cycle, and that data memory
 * sits outside and uses the stack address presented here.
 */
`timescale 1ns/1ps
`include "sfrpg_regs.vh"

module sfrpg_core (
   // Clock and reset
   input  wire       clk_in,
   input  wire       rst_n_in,
   // Direct-address SFR port
   input  wire [7:0] dir_addr_in,
   input  wire       dir_rd_in,
   input  wire       dir_wr_in,
   input  wire       dir_bit_in,
   input  wire [2:0] dir_bit_pos_in,
   input  wire [7:0] dir_wdata_in,
   // Sequencer stack events
   input  wire       push_in,
   input  wire       pop_in,
   input  wire       sp_inc_in,
   input  wire       sp_dec_in,
   input  wire       call_in,
   input  wire       ret_in,
   // Interrupt events
   input  wire       int_entry_in,
   input  wire [7:0] int_page_in,
   input  wire       interrupt_return_instr_in,
   // SFR port answers
   output reg  [7:0] dir_rdata_out,
   output reg        dir_sfr_out,
   output reg        dir_hit_out,
   output reg        dir_bit_err_out,
   // Stack and page state
   output reg  [7:0] stack_addr_out,
   output reg  [7:0] stack_pointer_out,
   output reg  [7:0] page_select_out,
   output reg        page_valid_out,
   output reg        auto_page_enable_out,
   // Debug record
   output wire [31:0] record_out,
   output wire [5:0]  record_depth_out,
   output wire        record_ovf_out,
   output wire        record_unf_out
);

   ////////////////////////////////////////////////////////////////////////
   // Decode helpers
   function is_sfr;
      input [7:0] a;
      begin
         is_sfr = (a >= `SFRPG_SFR_BASE);
      end
   endfunction

   function is_bit_addr;
      input [7:0] a;
      begin
         is_bit_addr = ((a & `SFRPG_BITADR_MASK) == 8'h00);
      end
   endfunction

   function page_ok;
      input [7:0] p;
      begin
         page_ok = (p <= `SFRPG_PAGE_3) || (p == `SFRPG_PAGE_F);
      end
   endfunction

   function [7:0] bit_merge;
      input [7:0] old;
      input [2:0] pos;
      input       val;
      reg   [7:0] m;
      begin
         m = `SFRPG_ONE << pos;
         bit_merge = val ? (old | m) : (old & ~m);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // State
   reg [7:0] stack_pointer_r;
   reg [7:0] page_select_reg_r;
   reg [7:0] page_stack_middle_r;
   reg [7:0] page_stack_bottom_r;
   reg [7:0] page_control_reg_r;
   reg [7:0] sp_nxt;
   reg [7:0] page_nxt;
   reg [7:0] mid_nxt;
   reg [7:0] bot_nxt;
   reg [7:0] pgcn_nxt;
   reg [7:0] stk_addr_nxt;
   reg [7:0] rdata_nxt;
   reg       hit_nxt;
   reg       bit_err_nxt;

   wire       sfr_acc = is_sfr(dir_addr_in) && (dir_rd_in || dir_wr_in);
   wire       bit_ok  = !dir_bit_in || is_bit_addr(dir_addr_in);
   wire       wr_ok   = dir_wr_in && sfr_acc && bit_ok;
   wire       auto_en = page_control_reg_r[`SFRPG_PGEN_BIT];
   // All-page registers decode without looking at the page; page control decodes only on page F
   wire       sel_sp   = (dir_addr_in == `SFRPG_ADDR_SP);
   wire       sel_page = (dir_addr_in == `SFRPG_ADDR_PAGE);
   wire       sel_mid  = (dir_addr_in == `SFRPG_ADDR_NEXT);
   wire       sel_bot  = (dir_addr_in == `SFRPG_ADDR_LAST);
   wire       sel_pgcn = (dir_addr_in == `SFRPG_ADDR_PGCN) &&
                         (page_select_reg_r == `SFRPG_PAGE_F);
   wire       sel_any  = sel_sp || sel_page || sel_mid || sel_bot || sel_pgcn;
   wire [7:0] sp_plus  = stack_pointer_r + `SFRPG_ONE;
   wire [7:0] sp_minus = stack_pointer_r - `SFRPG_ONE;

   ////////////////////////////////////////////////////////////////////////
   // Read mux; unmapped SFR addresses read zero
   always @* begin
      rdata_nxt = 8'h00;
      case (1'b1)
         sel_sp:   rdata_nxt = stack_pointer_r;
         sel_page: rdata_nxt = page_select_reg_r;
         sel_mid:  rdata_nxt = page_stack_middle_r;
         sel_bot:  rdata_nxt = page_stack_bottom_r;
         sel_pgcn: rdata_nxt = page_control_reg_r;
         default:  rdata_nxt = 8'h00;
      endcase
      if (!(dir_rd_in && sfr_acc))
         rdata_nxt = 8'h00;
      hit_nxt     = sfr_acc && sel_any;
      bit_err_nxt = sfr_acc && !bit_ok;
   end

   ////////////////////////////////////////////////////////////////////////
   // Stack pointer: sequencer events win over a same-cycle software write
   always @* begin
      sp_nxt       = stack_pointer_r;
      stk_addr_nxt = stack_addr_out;
      if (wr_ok && sel_sp)
         sp_nxt = dir_bit_in ? bit_merge(stack_pointer_r, dir_bit_pos_in, dir_wdata_in[0])
                             : dir_wdata_in;
      if (push_in || call_in) begin
         stk_addr_nxt = sp_plus;
         sp_nxt       = sp_plus;
      end else if (sp_inc_in) begin
         sp_nxt = sp_plus;
      end else if (pop_in || ret_in) begin
         stk_addr_nxt = stack_pointer_r;
         sp_nxt       = sp_minus;
      end else if (sp_dec_in) begin
         sp_nxt = sp_minus;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Page stack; software writes store only, never move the stack
   always @* begin
      page_nxt = page_select_reg_r;
      mid_nxt  = page_stack_middle_r;
      bot_nxt  = page_stack_bottom_r;
      pgcn_nxt = page_control_reg_r;
      if (wr_ok && sel_page)
         page_nxt = dir_wdata_in;
      if (wr_ok && sel_mid)
         mid_nxt = dir_wdata_in;
      if (wr_ok && sel_bot)
         bot_nxt = dir_wdata_in;
      if (wr_ok && sel_pgcn)
         pgcn_nxt = dir_wdata_in;
      // Hardware movement takes the same edge as vectoring
      if (auto_en && int_entry_in) begin
         bot_nxt  = page_stack_middle_r;
         mid_nxt  = page_select_reg_r;
         page_nxt = int_page_in;
      end else if (auto_en && interrupt_return_instr_in) begin
         page_nxt = page_stack_middle_r;
         mid_nxt  = page_stack_bottom_r;
         bot_nxt  = `SFRPG_EMPTY;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         stack_pointer_r      <= `SFRPG_SP_RST;
         page_select_reg_r    <= `SFRPG_PAGE_RST;
         page_stack_middle_r  <= `SFRPG_EMPTY;
         page_stack_bottom_r  <= `SFRPG_EMPTY;
         page_control_reg_r   <= `SFRPG_PGCN_RST;
         stack_addr_out       <= `SFRPG_SP_RST;
         stack_pointer_out    <= `SFRPG_SP_RST;
         page_select_out      <= `SFRPG_PAGE_RST;
         page_valid_out       <= 1'b1;
         auto_page_enable_out <= 1'b1;
         dir_rdata_out        <= 8'h00;
         dir_sfr_out          <= 1'b0;
         dir_hit_out          <= 1'b0;
         dir_bit_err_out      <= 1'b0;
      end else begin
         stack_pointer_r      <= sp_nxt;
         page_select_reg_r    <= page_nxt;
         page_stack_middle_r  <= mid_nxt;
         page_stack_bottom_r  <= bot_nxt;
         page_control_reg_r   <= pgcn_nxt;
         stack_addr_out       <= stk_addr_nxt;
         stack_pointer_out    <= sp_nxt;
         page_select_out      <= page_nxt;
         page_valid_out       <= page_ok(page_nxt);
         auto_page_enable_out <= pgcn_nxt[`SFRPG_PGEN_BIT];
         dir_rdata_out        <= rdata_nxt;
         dir_sfr_out          <= sfr_acc;
         dir_hit_out          <= hit_nxt;
         dir_bit_err_out      <= bit_err_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Record tracks every sequencer pointer event for the debug logic; software writes to the pointer are not recorded
   sfrpg_record u_record (
      .clk_in     (clk_in),
      .rst_n_in   (rst_n_in),
      .in1_in     (push_in || sp_inc_in),
      .in2_in     (call_in),
      .out1_in    (pop_in || sp_dec_in),
      .out2_in    (ret_in),
      .record_out (record_out),
      .depth_out  (record_depth_out),
      .ovf_out    (record_ovf_out),
      .unf_out    (record_unf_out)
   );

endmodule

// file: sfrpg_core_properties.sv
/* Checker for sfrpg_core: pointer, record, page stack and SFR port timing.
   Assumes one stack event per cycle from the sequencer. */
`timescale 1ns/1ps
module sfrpg_props (
   input wire        clk_in,
   input wire        rst_n_in,
   input wire [7:0]  dir_addr_in,
   input wire        dir_rd_in,
   input wire        dir_wr_in,
   input wire        dir_bit_in,
   input wire        push_in,
   input wire        pop_in,
   input wire        call_in,
   input wire        ret_in,
   input wire        int_entry_in,
   input wire [7:0]  int_page_in,
   input wire [7:0]  dir_rdata_out,
   input wire        dir_sfr_out,
   input wire        dir_bit_err_out,
   input wire [7:0]  stack_addr_out,
   input wire [7:0]  stack_pointer_out,
   input wire [7:0]  page_select_out,
   input wire        auto_page_enable_out,
   input wire [31:0] record_out,
   input wire [5:0]  record_depth_out,
   input wire        record_ovf_out
);
default clocking @(posedge clk_in); endclocking
default disable iff (!rst_n_in);
property p_push; push_in |=> stack_pointer_out == $past(stack_pointer_out) + 8'h01 && stack_addr_out == stack_pointer_out; endproperty
a_push: assert property (p_push) else $error("push pointer");
property p_pop; pop_in |=> stack_pointer_out == $past(stack_pointer_out) - 8'h01 && stack_addr_out == $past(stack_pointer_out); endproperty
a_pop: assert property (p_pop) else $error("pop pointer");
property p_rst; $rose(rst_n_in) |-> stack_pointer_out == 8'h07 && auto_page_enable_out; endproperty
a_rst: assert property (p_rst) else $error("reset state");
property p_call; call_in && record_depth_out < 6'd31 |=> record_out[1:0] == 2'b11 && record_out[31:2] == $past(record_out[29:0]); endproperty
a_call: assert property (p_call) else $error("call record");
property p_ret; ret_in && record_depth_out > 6'd1 |=> record_depth_out == $past(record_depth_out) - 6'd2; endproperty
a_ret: assert property (p_ret) else $error("return record");
property p_ovf; push_in && record_depth_out == 6'd32 |=> record_ovf_out && record_depth_out == 6'd32; endproperty
a_ovf: assert property (p_ovf) else $error("record overflow");
property p_low; (dir_rd_in || dir_wr_in) && !dir_addr_in[7] |=> !dir_sfr_out && dir_rdata_out == 8'h00; endproperty
a_low: assert property (p_low) else $error("low address routed");
property p_bit; dir_wr_in && dir_bit_in && dir_addr_in[7] && dir_addr_in[2:0] != 3'h0 |=> dir_bit_err_out; endproperty
a_bit: assert property (p_bit) else $error("bit access taken");
property p_ent; int_entry_in && auto_page_enable_out |=> page_select_out == $past(int_page_in); endproperty
a_ent: assert property (p_ent) else $error("entry page");
property p_off; int_entry_in && !auto_page_enable_out && !dir_wr_in |=> $stable(page_select_out); endproperty
a_off: assert property (p_off) else $error("page moved");
c_ent: cover property (int_entry_in && auto_page_enable_out);
c_ovf: cover property (record_ovf_out);
c_bit: cover property (dir_bit_err_out);
endmodule
////////////////////////////////////////
bind sfrpg_core sfrpg_props chk (.clk_in, .rst_n_in, .dir_addr_in, .dir_rd_in, .dir_wr_in, .dir_bit_in, .push_in,
   .pop_in, .call_in, .ret_in, .int_entry_in, .int_page_in, .dir_rdata_out, .dir_sfr_out, .dir_bit_err_out,
   .stack_addr_out, .stack_pointer_out, .page_select_out, .auto_page_enable_out, .record_out, .record_depth_out,
   .record_ovf_out);

// file: sfrpg_seq.sv
/* Sequencer and interrupt controller stand-in: one-cycle event strobes.
   Assumes a single caller of fire. */
`timescale 1ns/1ps
module sfrpg_seq (
   input  wire logic  clk_in,
   output logic [7:0] ev_out,
   output logic [7:0] page_out
);
// Bits: push pop inc dec call ret entry return
initial begin
   ev_out = 8'h00;
   page_out = 8'h00;
end
task automatic fire(input int code, input logic [7:0] pg);
   @(negedge clk_in);
   ev_out[code] = 1'b1;
   page_out = pg;
   @(negedge clk_in);
   ev_out = 8'h00;
   page_out = ~pg; // Page bus not held after the strobe
endtask
endmodule

// file: sfrpg_core_tb.sv
/* Self-checking bench for sfrpg_core against a queue-based model.
   Assumes the sequencer stand-in sfrpg_seq and the bound checker. */
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; \
   $display("ERROR %0t got %h want %h", $time, a, b); end end
module sfrpg_core_tb;
logic        clk_in = 0, rst_n_in = 0, rd = 0, wr = 0, bitf = 0;
logic [7:0]  addr = 0, wdata = 0, sp = 7, sa = 7, pg = 0, mid = 0, bot = 0, ctl = 1;
logic [2:0]  bpos = 0;
wire  [7:0]  ev, ipg, rdata, sp_o, sa_o, pg_o;
wire         sfr_o, hit_o, err_o, pv_o, ae_o, ovf_o, unf_o;
wire  [31:0] rec_o;
wire  [5:0]  dep_o;
int          num_errors = 0, samples_checked = 0;
bit          q[$];
logic [7:0]  regs[6] = '{8'h81, 8'h84, 8'h85, 8'h86, 8'h96, 8'h05};
logic [7:0]  pages[5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h0f};
sfrpg_core dut (.clk_in, .rst_n_in, .dir_addr_in(addr), .dir_rd_in(rd), .dir_wr_in(wr), .dir_bit_in(bitf),
   .dir_bit_pos_in(bpos), .dir_wdata_in(wdata), .push_in(ev[0]), .pop_in(ev[1]), .sp_inc_in(ev[2]),
   .sp_dec_in(ev[3]), .call_in(ev[4]), .ret_in(ev[5]), .int_entry_in(ev[6]), .int_page_in(ipg),
   .interrupt_return_instr_in(ev[7]), .dir_rdata_out(rdata), .dir_sfr_out(sfr_o), .dir_hit_out(hit_o),
   .dir_bit_err_out(err_o), .stack_addr_out(sa_o), .stack_pointer_out(sp_o), .page_select_out(pg_o),
   .page_valid_out(pv_o), .auto_page_enable_out(ae_o), .record_out(rec_o), .record_depth_out(dep_o),
   .record_ovf_out(ovf_o), .record_unf_out(unf_o));
sfrpg_seq seq (.clk_in, .ev_out(ev), .page_out(ipg));
initial forever #5 clk_in = ~clk_in;
////////////////////////////////////////
task automatic give_verdict;
   if (num_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
   else
      $display("CHECKS NOT OK");
   $finish;
endtask
task automatic chk_state;
   `CHK(sp_o, sp)
   `CHK(sa_o, sa)
   `CHK(pg_o, pg)
   `CHK(pv_o, pg inside {8'h00, 8'h01, 8'h02, 8'h03, 8'h0f})
   `CHK(ae_o, ctl[0])
   `CHK(dep_o, 6'(q.size()))
   foreach (q[i]) `CHK(rec_o[q.size() - 1 - i], q[i])
endtask
task automatic ev_do(input int c, input logic [7:0] p);
   bit o, u;
   int n;
   n = 0;
   seq.fire(c, p);
   case (c)
      0: begin sp++; sa = sp; q.push_back(0); end
      1: begin sa = sp; sp--; n = 1; end
      2: begin sp++; q.push_back(0); end
      3: begin sp--; n = 1; end
      4: begin sp++; sa = sp; q.push_back(1); q.push_back(1); end
      5: begin sa = sp; sp--; n = 2; end
      6: if (ctl[0]) begin bot = mid; mid = pg; pg = p; end
      default: if (ctl[0]) begin pg = mid; mid = bot; bot = 8'h00; end
   endcase
   o = q.size() > 32;
   while (q.size() > 32) q.pop_front();
   u = n > q.size();
   if (u) q.delete();
   else repeat (n) void'(q.pop_back());
   `CHK(ovf_o, o)
   `CHK(unf_o, u)
   chk_state;
endtask
task automatic sfr(input logic [7:0] a, input bit w, input bit b, input logic [7:0] d);
   logic [7:0] r;
   bit h;
   h = 1;
   case (a)
      8'h81: r = sp;
      8'h84: r = pg;
      8'h85: r = mid;
      8'h86: r = bot;
      8'h96: begin r = ctl; h = pg == 8'h0f; end
      default: h = 0;
   endcase
   if (!h || w) r = 8'h00;
   @(negedge clk_in);
   addr = a; rd = !w; wr = w; bitf = b; wdata = d; bpos = 3'($urandom);
   @(negedge clk_in);
   rd = 0; wr = 0;
   `CHK(rdata, r)
   `CHK(sfr_o, a[7])
   `CHK(err_o, b && a[7] && a[2:0] != 3'h0)
   `CHK(hit_o, h)
   if (w && h && !b)
      case (a)
         8'h81: sp = d;
         8'h84: pg = d;
         8'h85: mid = d;
         8'h86: bot = d;
         default: ctl = d;
      endcase
   chk_state;
endtask
////////////////////////////////////////
initial begin
   bit w;
   void'($urandom(35809));
   repeat (3) @(negedge clk_in);
   rst_n_in = 1;
   chk_state;
   sfr(8'h81, 0, 0, 0);
   sfr(8'h05, 1, 0, 8'h5a);
   sfr(8'h82, 0, 0, 0);
   repeat (34) ev_do(0, 0);
   repeat (35) ev_do(1, 0);
   ev_do(4, 0);
   ev_do(5, 0);
   sfr(8'h84, 1, 0, 8'h0f);
   sfr(8'h96, 1, 0, 8'h00);
   ev_do(6, 8'h02);
   ev_do(7, 0);
   sfr(8'h96, 1, 0, 8'h01);
   ev_do(6, 8'h02);
   sfr(8'h86, 1, 0, 8'h55);
   ev_do(6, 8'h00);
   ev_do(7, 0);
   ev_do(7, 0);
   repeat (300) begin
      w = 1'($urandom_range(1));
      if ($urandom_range(1)) ev_do($urandom_range(7), pages[$urandom_range(4)]);
      else sfr(regs[$urandom_range(5)], w, w && $urandom_range(3) == 0, 8'($urandom));
      repeat ($urandom_range(2)) @(negedge clk_in);
   end
   give_verdict;
end
initial begin
   #200000;
   num_errors++;
   give_verdict;
end
endmodule
